// *** pcie_outbound_window_xlate_tb.sv ***
`timescale 1ns/10ps
`include "powx_regs.svh"
module pcie_outbound_window_xlate_tb import powx_pkg::*;;
	logic clk_sys = 0, rstn = 0, clk_en = 1, rd_valid, link_valid, acc_err, w;
	logic [31:0] rd_data, x, a, d;
	powx_req_t req = '0;
	powx_link_t link;
	int error_cnt = 0, n_tests = 0, cyc = 0;
	always #25 clk_sys = ~clk_sys;
	powx_outbound_xlate u_dut(.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .req(req),
		.rd_valid(rd_valid), .rd_data(rd_data), .link_valid(link_valid), .link(link),
		.acc_err(acc_err));
	powx_ep_model u_ep(.clk_sys(clk_sys), .clk_en(clk_en), .link_valid(link_valid),
		.link(link));
	task print_verdict;
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [31:0] s, e);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	// One access per falling edge; answers have landed by the next one
	task acc(input logic wr, input logic [31:0] ad, dt);
		req <= '{1'b1, wr, ad, dt};
		@(negedge clk_sys);
	endtask
	function logic [31:0] xl(input logic [31:0] t, ad);
		return (t << 12) | (ad & 32'h1fff_ffff);
	endfunction
	// Hang guard
	always @(posedge clk_sys) if (++cyc == 2000) begin
		error_cnt++;
		print_verdict;
	end
	initial begin
		x = $urandom(32'h7773_9f93);
		repeat (8) @(negedge clk_sys);
		rstn = 1;
		for (int i = 0; i < 3; i++) begin
			acc(0, 32'he000_ac20 + 8 * i, 0);
			chk(rd_data, 0);
		end
		acc(1, 32'h8000_0000, 0);
		chk(acc_err, 1);
		// Host setup of the window before its first use
		acc(1, `POWX_ADDR_ATTR, 32'h8004_401c);
		acc(1, `POWX_ADDR_BASE, 32'h0008_0000);
		acc(0, `POWX_ADDR_ATTR, 0);
		chk(rd_data, 32'h8004_401c);
		$display("registers done");
		for (int i = 0; i < 40; i++) begin
			x = $urandom % 2 ? 32'h0008_0000 : 0;
			acc(1, `POWX_ADDR_XLATE, x);
			a = i == 0 ? 32'h9fff_fffc : {3'b100, 29'($urandom)};
			d = $urandom;
			w = 1'($urandom);
			acc(w, a, d);
			chk(link_valid, 1);
			chk(link.addr, xl(x, a));
			chk(32'(link.ttype), 4);
			chk(32'(link.write), 32'(w));
			chk(link.data, w ? d : 32'h0000_0000);
		end
		$display("random done");
		acc(1, 32'h8000_0040, 32'h1234_5678);
		acc(0, 32'ha000_0000, 0);
		chk(u_ep.mem[xl(x, 32'h8000_0040)], 32'h1234_5678);
		chk({acc_err, rd_valid, rd_data[0]}, 3'b110);
		acc(1, `POWX_ADDR_ATTR, 32'h8004_001c);
		acc(1, 32'h8000_0000, 5);
		chk(acc_err, 1);
		acc(1, `POWX_ADDR_ATTR, 32'h8004_400b);
		acc(0, 32'h8000_1000, 0);
		chk(acc_err, 1);
		acc(0, 32'h8000_0ffc, 0);
		chk(link_valid, 1);
		// Frozen cycle: request not taken, issue pulse held
		clk_en <= 1'b0;
		acc(0, `POWX_ADDR_ATTR, 0);
		chk({rd_valid, link_valid}, 2'b01);
		clk_en <= 1'b1;
		@(negedge clk_sys);
		chk(rd_valid, 1);
		chk(rd_data, 32'h8004_400b);
		// Mid-run reset clears the window registers
		rstn = 0;
		@(negedge clk_sys);
		rstn = 1;
		acc(0, `POWX_ADDR_ATTR, 0);
		chk(rd_data, `POWX_RST_ATTR);
		req <= '0;
		$display("corners done");
		print_verdict;
	end
endmodule

// *** powx_ep_model.sv ***
`timescale 1ns/10ps
module powx_ep_model import powx_pkg::*; (
	input wire logic clk_sys,
	input wire logic clk_en,
	input wire logic link_valid,
	input wire powx_link_t link
);
	logic [31:0] mem [logic [31:0]];
	// Flat endpoint space: one sparse word store, written by each issued write
	always @(posedge clk_sys) begin
		if (clk_en && link_valid && link.write) mem[link.addr] = link.data;
	end
endmodule

// *** powx_outbound_xlate.sv ***
// Summary of operation
// - Local window with target code 0x2 over 512 MB routes accesses to the controller.
// - Attribute enable bit set (word 0x8004401c) turns outbound translation on.
// - Read type code 4'b0100 sends window reads out as PCIe memory reads.
// - Write type code 4'b0100 sends window writes out as PCIe memory writes.
// - Six-bit size field sets window extent; code 6'b011100 means 512 MB.
// - Window base register selects matched local base; 0x00080000 means 0x80000000.
// - Translation 0x00000000 sends window hits starting at PCIe address zero.
// - Translation 0x00080000 relocates outgoing addresses to start at 0x80000000.
`timescale 1ns/10ps
`include "powx_regs.svh"
module powx_outbound_xlate import powx_pkg::*; #(
	parameter logic [31:0] LAW_BASE = `POWX_LAW_BASE,
	parameter logic [5:0] LAW_SIZE = `POWX_LAW_SIZE,
	parameter logic [3:0] LAW_TARGET = `POWX_LAW_TGT_PCIE
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic clk_en,
	input wire powx_req_t req,
	output logic rd_valid,
	output logic [31:0] rd_data,
	output logic link_valid,
	output powx_link_t link,
	output logic acc_err
);

	// Register state and next values
	logic [31:0] xlate_r, xlate_nxt;
	logic [31:0] base_r, base_nxt;
	logic [31:0] attr_r, attr_nxt;
	logic rd_valid_r, rd_valid_nxt;
	logic [31:0] rd_data_r, rd_data_nxt;
	logic link_valid_r, link_valid_nxt;
	powx_link_t link_r, link_nxt;
	logic acc_err_r, acc_err_nxt;

	logic law_hit;
	logic win_hit;
	logic [31:0] law_off;
	logic [31:0] win_off;
	logic [31:0] win_base;
	logic [31:0] pcie_base;
	logic [3:0] read_transaction_type;
	logic [3:0] write_transaction_type;
	logic [3:0] ttype;
	logic is_reg;
	logic sel_xlate;
	logic sel_base;
	logic sel_attr;
	logic win_en;
	logic [5:0] outbound_window_size;
	logic fwd_ok;
	logic refuse;
	logic [31:0] fwd_addr;

	// Attribute fields and page-unit addresses
	assign win_en = attr_r[`POWX_ATTR_EN];
	assign outbound_window_size = attr_r[`POWX_ATTR_OWS_HI:`POWX_ATTR_OWS_LO];
	assign read_transaction_type = attr_r[`POWX_ATTR_RTT_HI:`POWX_ATTR_RTT_LO];
	assign write_transaction_type = attr_r[`POWX_ATTR_WTT_HI:`POWX_ATTR_WTT_LO];
	assign win_base = base_r << `POWX_PAGE_SHIFT;
	assign pcie_base = xlate_r << `POWX_PAGE_SHIFT;
	assign ttype = req.write ? write_transaction_type : read_transaction_type;

	// Register page decode; register addresses are never forwarded
	assign sel_xlate = (req.addr == `POWX_ADDR_XLATE);
	assign sel_base = (req.addr == `POWX_ADDR_BASE);
	assign sel_attr = (req.addr == `POWX_ADDR_ATTR);
	assign is_reg = sel_xlate || sel_base || sel_attr;

	// Forward only a routed, enabled window hit of memory type; refuse the rest
	assign fwd_ok = req.valid && !is_reg && law_hit && win_hit
		&& (ttype == `POWX_TT_MEM);
	assign refuse = req.valid && !is_reg && !fwd_ok;
	assign fwd_addr = pcie_base | win_off;

	// Routed local window: only a PCIe target hands accesses to this controller
	powx_window_match #(
		.AW(32)
	) u_law_match (
		.enable(LAW_TARGET == `POWX_LAW_TGT_PCIE),
		.base(LAW_BASE),
		.size_code(LAW_SIZE),
		.addr(req.addr),
		.hit(law_hit),
		.offset(law_off)
	);

	// Outbound window match inside the routed range
	powx_window_match #(
		.AW(32)
	) u_win_match (
		.enable(win_en),
		.base(win_base),
		.size_code(outbound_window_size),
		.addr(req.addr),
		.hit(win_hit),
		.offset(win_off)
	);

	// Register writes from the local processor
	always_comb begin
		xlate_nxt = xlate_r;
		base_nxt = base_r;
		attr_nxt = attr_r;
		if (req.valid && req.write) begin
			case (req.addr)
				`POWX_ADDR_XLATE: begin
					xlate_nxt = req.wdata;
				end
				`POWX_ADDR_BASE: begin
					base_nxt = req.wdata;
				end
				`POWX_ADDR_ATTR: begin
					attr_nxt = req.wdata;
				end
				default: begin
					xlate_nxt = xlate_r;
				end
			endcase
		end
	end

	// Window registers, frozen while the clock enable is low
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			xlate_r <= `POWX_RST_XLATE;
			base_r <= `POWX_RST_BASE;
			attr_r <= `POWX_RST_ATTR;
		end else if (clk_en) begin
			xlate_r <= xlate_nxt;
			base_r <= base_nxt;
			attr_r <= attr_nxt;
		end
	end

	// Read answers: register contents, or zero for a refused read
	always_comb begin
		rd_valid_nxt = 1'b0;
		rd_data_nxt = rd_data_r;
		if (req.valid && !req.write) begin
			if (is_reg) begin
				rd_valid_nxt = 1'b1;
				case (req.addr)
					`POWX_ADDR_XLATE: begin
						rd_data_nxt = xlate_r;
					end
					`POWX_ADDR_BASE: begin
						rd_data_nxt = base_r;
					end
					default: begin
						rd_data_nxt = attr_r;
					end
				endcase
			end else if (refuse) begin
				// A refused read still completes so the processor never stalls
				rd_valid_nxt = 1'b1;
				rd_data_nxt = 32'h0000_0000;
			end
		end
	end

	// Read answer registers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rd_valid_r <= 1'b0;
			rd_data_r <= 32'h0000_0000;
		end else if (clk_en) begin
			rd_valid_r <= rd_valid_nxt;
			rd_data_r <= rd_data_nxt;
		end
	end

	// Outbound issue: memory read or write with translated address
	always_comb begin
		link_valid_nxt = 1'b0;
		link_nxt = link_r;
		if (fwd_ok) begin
			link_valid_nxt = 1'b1;
			link_nxt.write = req.write;
			link_nxt.ttype = ttype;
			link_nxt.addr = fwd_addr;
			link_nxt.data = req.write ? req.wdata : 32'h0000_0000;
		end
	end

	// Link registers; fields stand until the next issue
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			link_valid_r <= 1'b0;
			link_r <= '0;
		end else if (clk_en) begin
			link_valid_r <= link_valid_nxt;
			link_r <= link_nxt;
		end
	end

	// Refusal: outside the window, window disabled or unsupported type
	always_comb begin
		acc_err_nxt = refuse;
	end

	// Refusal pulse register
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			acc_err_r <= 1'b0;
		end else if (clk_en) begin
			acc_err_r <= acc_err_nxt;
		end
	end

	assign rd_valid = rd_valid_r;
	assign rd_data = rd_data_r;
	assign link_valid = link_valid_r;
	assign link = link_r;
	assign acc_err = acc_err_r;

endmodule

// *** powx_outbound_xlate_sva.sv ***
`timescale 1ns/10ps
module powx_chk import powx_pkg::*; (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic clk_en,
	input wire powx_req_t req,
	input wire logic rd_valid,
	input wire logic [31:0] rd_data,
	input wire logic link_valid,
	input wire powx_link_t link,
	input wire logic acc_err
);
	// Only enabled edges count; frozen cycles hold everything
	default clocking @(posedge clk_sys iff clk_en); endclocking
	default disable iff (!rstn);
	// Access outside the routed window and off the register page
	sequence s_out;
		req.valid && req.addr[31:29] != 3'b100 && req.addr[31:16] != 16'he000;
	endsequence
	property p_out; s_out |=> acc_err && !link_valid; endproperty
	property p_tt; link_valid |-> link.ttype == 4'h4; endproperty
	property p_wr; link_valid |-> link.write == $past(req.write); endproperty
	property p_dat; link_valid && link.write |-> link.data == $past(req.wdata); endproperty
	property p_src; link_valid |-> $past(req.valid) && $past(req.addr[31:29]) == 3'b100;
	endproperty
	property p_pg; link_valid |-> link.addr[11:0] == $past(req.addr[11:0]); endproperty
	property p_rd; rd_valid |-> $past(req.valid) && !$past(req.write); endproperty
	property p_ex; !(link_valid && acc_err); endproperty
	a_out: assert property (p_out) else $error("miss not refused");
	a_tt: assert property (p_tt) else $error("bad link type");
	a_wr: assert property (p_wr) else $error("bad direction");
	a_dat: assert property (p_dat) else $error("bad write data");
	a_src: assert property (p_src) else $error("issue without hit");
	a_pg: assert property (p_pg) else $error("page offset lost");
	a_rd: assert property (p_rd) else $error("stray read answer");
	a_ex: assert property (p_ex) else $error("issue and refusal");
endmodule
bind powx_outbound_xlate powx_chk u_chk(.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en),
	.req(req), .rd_valid(rd_valid), .rd_data(rd_data), .link_valid(link_valid),
	.link(link), .acc_err(acc_err));

// *** powx_pkg.sv ***
package powx_pkg;

	// Local processor access toward the controller
	typedef struct packed {
		logic valid;
		logic write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} powx_req_t;

	// Transaction issued on the PCIe link
	typedef struct packed {
		logic write;
		logic [3:0] ttype;
		logic [31:0] addr;
		logic [31:0] data;
	} powx_link_t;

endpackage

// *** powx_regs.svh ***
`ifndef POWX_REGS_SVH
`define POWX_REGS_SVH

// Register addresses in the local processor map
`define POWX_ADDR_XLATE 32'he000_ac20
`define POWX_ADDR_BASE 32'he000_ac28
`define POWX_ADDR_ATTR 32'he000_ac30

// Reset values: window disabled, no translation
`define POWX_RST_XLATE 32'h0000_0000
`define POWX_RST_BASE 32'h0000_0000
`define POWX_RST_ATTR 32'h0000_0000

// Attribute word field positions
`define POWX_ATTR_EN 31
`define POWX_ATTR_RTT_HI 19
`define POWX_ATTR_RTT_LO 16
`define POWX_ATTR_WTT_HI 15
`define POWX_ATTR_WTT_LO 12
`define POWX_ATTR_OWS_HI 5
`define POWX_ATTR_OWS_LO 0

// Transaction type code for PCIe memory read and write
`define POWX_TT_MEM 4'h4

// Base and translation registers hold addresses in 4 KB units
`define POWX_PAGE_SHIFT 12

// Routed local window defaults: base, size code (512 MB), PCIe target
`define POWX_LAW_BASE 32'h8000_0000
`define POWX_LAW_SIZE 6'h1c
`define POWX_LAW_TGT_PCIE 4'h2

`endif

// *** powx_window_match.sv ***
`timescale 1ns/10ps
module powx_window_match #(
	parameter int AW = 32
) (
	input wire logic enable,
	input wire logic [AW-1:0] base,
	input wire logic [5:0] size_code,
	input wire logic [AW-1:0] addr,
	output logic hit,
	output logic [AW-1:0] offset
);

	logic [63:0] span;
	logic [AW-1:0] mask;

	// Window extent is two to the power of (size code + 1) bytes
	always_comb begin
		span = (64'h0000_0000_0000_0001 << (7'(size_code) + 7'h01)) - 64'h0000_0000_0000_0001;
		mask = span[AW-1:0];
		hit = enable && ((addr & ~mask) == (base & ~mask));
		offset = addr & mask;
	end

endmodule
